// >>> logic/trace_sampler_map.svh
// constants of the trace sampler: sizes, fill shares, compression and self-test figures
// assumes inclusion by bare name from the package and the design modules
`ifndef TRACE_SAMPLER_MAP_SVH
`define TRACE_SAMPLER_MAP_SVH

`define SAMPLE_W 16
`define GROUP_N 8
`define GROUP_SEL_W 4
`define DEPTH_DEF 128
`define CMP_FORCE_RUN 64
`define PCT_EARLY 10
`define PCT_MIDDLE 50
`define PCT_LATE 90
`define PCT_WHOLE 100
`define INT_RD_LAT 2'h1
`define EXT_RD_LAT 2'h3
`define TEST_PATTERN 16'ha5c3

`endif

// >>> logic/trace_sampler_pkg.sv
// types shared by the trace sampler modules
// assumes the constant header is on the include path
`include "trace_sampler_map.svh"

package trace_sampler_pkg;

   // middle comes first so that an all-zero setting is the middle position
   typedef enum logic [1:0] {POS_MIDDLE, POS_EARLY, POS_LATE} trig_pos_e;

   typedef enum logic [1:0] {MODE_NORMAL, MODE_QUAL_FILL, MODE_QUAL_INTR, MODE_ALWAYS_ARMED} sample_mode_e;

   typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_POST, ST_DONE, ST_TEST_WR, ST_TEST_RD} cap_state_e;

endpackage

// >>> logic/trace_mem_if.sv
// write and read port between the capture engine and its on-chip trace memory
// assumes one clock shared by both ends
`timescale 1ns/1ns

interface trace_mem_if #(
   parameter int AW = 8,
   parameter int W = 16
) ();
   logic we;
   logic [AW-1:0] waddr;
   logic [W-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [W-1:0] rdata;

   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// >>> logic/trace_mem.sv
// simple dual-port trace memory with registered read data
// assumes one clock; read data appear one edge after the address
`timescale 1ns/1ns

module trace_mem #(
   parameter int AW = 8,
   parameter int W = 16
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   trace_mem_if.mem port
);
   logic [W-1:0] store [2**AW];

   // array itself carries no reset, so it maps onto block ram
   always_ff @(posedge sys_clk) begin
      if (port.we) begin
         store[port.waddr] <= port.wdata;
      end
   end

   // read register
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         port.rdata <= '0;
      end else begin
         port.rdata <= store[port.raddr];
      end
   end
endmodule // trace_mem

// >>> logic/trace_sampler.sv
// capture engine of an embedded logic analyser: group select, compression, trigger placement,
// qualified and always-armed sampling, trace storage on chip or in external sram, sram self-test
// assumes sys_clk is the sample clock and that all control and probe inputs come from its domain
`timescale 1ns/1ns
`include "trace_sampler_map.svh"

module trace_sampler import trace_sampler_pkg::*; #(
   parameter int DEPTH = `DEPTH_DEF,
   parameter bit EXT_MEM = 1'b0,
   parameter int STACK = 1,
   parameter bit QUAL_EN = 1'b1,
   parameter bit ALWAYS_EN = 1'b1,
   localparam int AW = $clog2(DEPTH)
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [`GROUP_N*`SAMPLE_W-1:0] group_data,
   input wire logic [`GROUP_SEL_W-1:0] group_num,
   input wire logic trigger,
   input wire logic arm,
   input wire logic stop,
   input wire logic selftest_req,
   input wire sample_mode_e mode,
   input wire trig_pos_e trig_pos,
   input wire logic compress_en,
   input wire logic [`SAMPLE_W-1:0] cmp_mask,
   input wire logic [AW-1:0] rd_addr,
   output logic [`SAMPLE_W-1:0] rd_data,
   output logic busy,
   output logic capture_done,
   output logic [AW-1:0] trig_addr,
   output logic [AW-1:0] oldest_addr,
   output logic [AW:0] entry_count,
   output logic held_bank,
   output logic test_done,
   output logic test_fail,
   output logic [AW:0] sram_addr,
   output logic [`SAMPLE_W-1:0] sram_wdata,
   output logic sram_data_oe,
   output logic sram_we_n,
   output logic [1:0] sram_card_sel,
   input wire logic [`SAMPLE_W-1:0] sram_rdata
);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [1:0] RD_LAT = EXT_MEM ? `EXT_RD_LAT : `INT_RD_LAT;

   // probe group decode; out-of-range numbers fall back to the first group
   function automatic logic [2:0] group_index(input logic [`GROUP_SEL_W-1:0] num);
      if (num >= `GROUP_SEL_W'(1) && num <= `GROUP_SEL_W'(`GROUP_N)) begin
         return 3'(num - `GROUP_SEL_W'(1));
      end
      return 3'h0;
   endfunction

   // samples kept ahead of the trigger for each position
   function automatic logic [AW:0] pre_len(input trig_pos_e pos);
      int pct;
      case (pos)
         POS_EARLY: pct = `PCT_EARLY;
         POS_LATE: pct = `PCT_LATE;
         default: pct = `PCT_MIDDLE;
      endcase
      return (AW+1)'((DEPTH * pct) / `PCT_WHOLE);
   endfunction

   // self-test word for an address; the address folded in catches stuck or shorted address lines
   function automatic logic [`SAMPLE_W-1:0] test_pattern(input logic [AW:0] a);
      return `TEST_PATTERN ^ `SAMPLE_W'(a);
   endfunction

   trace_mem_if #(.AW(AW+1), .W(`SAMPLE_W)) mif ();

   cap_state_e state_reg;
   logic [AW-1:0] wr_ptr_reg;
   logic [AW:0] fill_reg;
   logic [AW:0] post_reg;
   logic [AW-1:0] trig_reg;
   logic bank_reg;
   logic [`SAMPLE_W-1:0] last_reg;
   logic [6:0] same_reg;
   logic first_reg;
   logic [AW:0] t_ptr_reg;
   logic [1:0] t_wait_reg;

   logic [`SAMPLE_W-1:0] sel_data;
   logic running, qual, always_m, trig_hit, cand, changed, store_ok, wr_en;
   logic post_last, qfill_full, snap, t_last, t_cmp;
   logic [AW-1:0] ptr_next;
   logic [AW:0] fill_next;

   // probe group routing to the capture path
   assign sel_data = group_data[group_index(group_num)*`SAMPLE_W +: `SAMPLE_W];

   // mode decode; a mode that the build left out behaves as plain sampling
   assign running = (state_reg == ST_RUN) || (state_reg == ST_POST);
   assign qual = QUAL_EN && (mode == MODE_QUAL_FILL || mode == MODE_QUAL_INTR);
   assign always_m = ALWAYS_EN && (mode == MODE_ALWAYS_ARMED);

   // trigger taken only once enough history is in the buffer
   assign trig_hit = (state_reg == ST_RUN) && !qual && trigger && (fill_reg >= pre_len(trig_pos));
   // qualified sampling offers one sample per true trigger cycle
   assign cand = running && (qual ? trigger : 1'b1);
   // change detection ignores masked bits
   assign changed = |((sel_data ^ last_reg) & ~cmp_mask);
   // forced store on the 64th unchanged cycle keeps the time base recoverable
   assign store_ok = !compress_en || first_reg || changed || trig_hit || (same_reg == 7'(`CMP_FORCE_RUN - 1));
   assign wr_en = cand && store_ok;

   assign ptr_next = wr_en ? ((wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1)) : wr_ptr_reg;
   assign fill_next = (wr_en && fill_reg != DEPTH_C) ? fill_reg + (AW+1)'(1) : fill_reg;
   assign post_last = (state_reg == ST_POST) && wr_en && (post_reg == (AW+1)'(1));
   assign qfill_full = (state_reg == ST_RUN) && mode == MODE_QUAL_FILL && qual && fill_next == DEPTH_C;
   assign snap = post_last || (running && !always_m && (stop || qfill_full));
   assign t_last = t_ptr_reg == {(AW+1){1'b1}};
   assign t_cmp = (state_reg == ST_TEST_RD) && (t_wait_reg == RD_LAT);

   // capture sequencing
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE, ST_DONE: begin
               if (selftest_req) begin
                  state_reg <= ST_TEST_WR;
               end else if (arm) begin
                  state_reg <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (stop || qfill_full) begin
                  state_reg <= ST_DONE;
               end else if (trig_hit) begin
                  state_reg <= ST_POST;
               end
            end
            ST_POST: begin
               if (stop) begin
                  state_reg <= ST_DONE;
               end else if (post_last) begin
                  state_reg <= always_m ? ST_RUN : ST_DONE;
               end
            end
            ST_TEST_WR: begin
               if (t_last) begin
                  state_reg <= ST_TEST_RD;
               end
            end
            ST_TEST_RD: begin
               if (t_cmp && t_last) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // write pointer, fill level and post-trigger count, all on the sample edge
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         fill_reg <= '0;
         post_reg <= '0;
         trig_reg <= '0;
         bank_reg <= 1'b0;
      end else if ((state_reg == ST_IDLE || state_reg == ST_DONE) && arm && !selftest_req) begin
         wr_ptr_reg <= '0;
         fill_reg <= '0;
         bank_reg <= 1'b0;
      end else if (post_last && always_m) begin
         wr_ptr_reg <= '0; // fresh snapshot goes to the other bank
         fill_reg <= '0;
         bank_reg <= ~bank_reg;
      end else begin
         wr_ptr_reg <= ptr_next; // qualified-interrupt mode just wraps
         fill_reg <= fill_next;
         if (trig_hit) begin
            trig_reg <= wr_ptr_reg;
            post_reg <= DEPTH_C - pre_len(trig_pos) - (AW+1)'(1); // trigger sample counts as post
         end else if (state_reg == ST_POST && wr_en) begin
            post_reg <= post_reg - (AW+1)'(1);
         end
      end
   end

   // result of the last finished capture; in always-armed mode it survives the rearm
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         held_bank <= 1'b0;
         trig_addr <= '0;
         oldest_addr <= '0;
         entry_count <= '0;
      end else if (snap) begin
         held_bank <= bank_reg;
         oldest_addr <= (fill_next == DEPTH_C) ? ptr_next : '0;
         trig_addr <= qual ? ((fill_next == DEPTH_C) ? ptr_next : '0) : trig_reg;
         entry_count <= fill_next;
      end
   end

   // compression history
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         last_reg <= '0;
         same_reg <= '0;
         first_reg <= 1'b1;
      end else if (state_reg != ST_RUN && state_reg != ST_POST) begin
         same_reg <= '0;
         first_reg <= 1'b1;
      end else if (wr_en) begin
         last_reg <= sel_data;
         same_reg <= '0;
         first_reg <= 1'b0;
      end else if (cand) begin
         same_reg <= same_reg + 7'h1;
      end
   end

   // self-test walk over every storage word: write pass, then paced read-back
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         t_ptr_reg <= '0;
         t_wait_reg <= '0;
         test_done <= 1'b0;
         test_fail <= 1'b0;
      end else if ((state_reg == ST_IDLE || state_reg == ST_DONE) && selftest_req) begin
         t_ptr_reg <= '0;
         t_wait_reg <= '0;
         test_done <= 1'b0;
         test_fail <= 1'b0;
      end else if (state_reg == ST_TEST_WR) begin
         t_ptr_reg <= t_ptr_reg + (AW+1)'(1);
      end else if (state_reg == ST_TEST_RD) begin
         if (t_cmp) begin
            t_wait_reg <= '0;
            t_ptr_reg <= t_ptr_reg + (AW+1)'(1);
            test_done <= t_last;
            if (mif.rdata != test_pattern(t_ptr_reg)) begin
               test_fail <= 1'b1;
            end
         end else begin
            t_wait_reg <= t_wait_reg + 2'h1;
         end
      end
   end

   // storage port: capture writes, test traffic, host readout of the held bank
   always_comb begin
      if (state_reg == ST_TEST_WR) begin
         mif.we = 1'b1;
         mif.waddr = t_ptr_reg;
         mif.wdata = test_pattern(t_ptr_reg);
      end else begin
         mif.we = wr_en;
         mif.waddr = {bank_reg, wr_ptr_reg};
         mif.wdata = sel_data;
      end
      mif.raddr = (state_reg == ST_TEST_RD) ? t_ptr_reg : {held_bank, rd_addr};
   end

   assign rd_data = mif.rdata;
   assign busy = running || state_reg == ST_TEST_WR || state_reg == ST_TEST_RD;
   assign capture_done = state_reg == ST_DONE;

   // storage choice fixed at build time
   generate
      if (EXT_MEM) begin : g_ext
         logic [`SAMPLE_W-1:0] rd_meta_reg;
         logic [`SAMPLE_W-1:0] rd_sync_reg;
         // sram pins registered; the read data cross in through two flops
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               sram_addr <= '0;
               sram_wdata <= '0;
               sram_data_oe <= 1'b0;
               sram_we_n <= 1'b1;
               sram_card_sel <= 2'h1;
               rd_meta_reg <= '0;
               rd_sync_reg <= '0;
            end else begin
               sram_addr <= mif.we ? mif.waddr : mif.raddr;
               sram_wdata <= mif.wdata;
               sram_data_oe <= mif.we;
               sram_we_n <= ~mif.we;
               rd_meta_reg <= sram_rdata;
               rd_sync_reg <= rd_meta_reg;
               // second card of a stack holds the upper bank, same at every location
               if (STACK == 2) begin
                  sram_card_sel <= (mif.we ? mif.waddr[AW] : mif.raddr[AW]) ? 2'h2 : 2'h1;
                  sram_addr[AW] <= 1'b0;
               end else begin
                  sram_card_sel <= 2'h1;
               end
            end
         end
         assign mif.rdata = rd_sync_reg;
      end else begin : g_int
         trace_mem #(.AW(AW+1), .W(`SAMPLE_W)) u_mem (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .port(mif.mem)
         );
         assign sram_addr = '0;
         assign sram_wdata = '0;
         assign sram_data_oe = 1'b0;
         assign sram_we_n = 1'b1;
         assign sram_card_sel = 2'h0;
      end
   endgenerate

   cmp_force_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      compress_en && cand && same_reg == 7'd63 |-> wr_en) else $error("no forced store after 64 idle cycles");
   ptr_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr_ptr_reg <= AW'(DEPTH - 1) && fill_reg <= DEPTH_C) else $error("pointer beyond depth");
   early_pre_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      trig_hit && trig_pos == POS_EARLY && !stop |-> fill_reg >= (AW+1)'(DEPTH / 10)
      ##1 (state_reg == ST_POST)) else $error("early trigger before history");
   middle_pre_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_reg == ST_RUN && !qual && trigger && trig_pos == POS_MIDDLE && fill_reg < (AW+1)'(DEPTH / 2) && !stop
      |=> state_reg == ST_RUN) else $error("middle trigger taken too soon");
   late_post_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      trig_hit && trig_pos == POS_LATE && !always_m |-> ##1 post_reg == (AW+1)'(DEPTH - (DEPTH * 9) / 10 - 1))
      else $error("late post count wrong");
   qual_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      running && qual |-> (wr_en == trigger) || (compress_en && !wr_en)) else $error("qualified write mismatch");
   qfill_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      qfill_full && !stop |=> capture_done && entry_count == DEPTH_C) else $error("qualified fill did not stop");
   rearm_bank_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      post_last && always_m && !stop |=> state_reg == ST_RUN && held_bank != bank_reg) else $error("no rearm");
   mask_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      compress_en && cand && !first_reg && !trig_hit && same_reg < 7'd63 && (((sel_data ^ last_reg) & ~cmp_mask) == '0)
      |-> !wr_en) else $error("masked change stored");
   test_end_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      t_cmp && t_last |=> state_reg == ST_IDLE && test_done) else $error("self-test did not finish");
endmodule // trace_sampler

// >>> verification/sram_model.sv
// behavioural external sample memory: a stack of cards, asynchronous read, write on the rising edge
// assumes the sampler changes address, data and card select just after the clock edge
`timescale 1ns/1ns

module sram_model (
   input wire logic sys_clk,
   input wire logic [7:0] sram_addr,
   input wire logic [15:0] sram_wdata,
   input wire logic sram_data_oe,
   input wire logic sram_we_n,
   input wire logic [1:0] sram_card_sel,
   input wire logic stuck_fault,
   output logic [15:0] sram_rdata
);
   logic [15:0] mem [int];
   logic [15:0] last_q = 16'h0;
   int key;

   // a released or unwritten bus shows the inverse of its last value, never a stale copy
   always @* begin
      key = int'({sram_card_sel, sram_addr});
      if (sram_data_oe || sram_card_sel == 2'h0 || !mem.exists(key))
         sram_rdata = ~last_q;
      else
         sram_rdata = mem[key] ^ {15'h0, stuck_fault}; // fault flips bit 0 on readback only
   end

   // a card stores only while selected; the card bit extends the stack depth
   always @(posedge sys_clk) begin
      last_q <= sram_rdata;
      if (!sram_we_n && sram_card_sel != 2'h0)
         mem[key] = sram_wdata;
   end
endmodule // sram_model

// >>> verification/trace_sampler_tb_top.sv
// self-checking bench of the trace sampler: an on-chip build and an external two-card build side by side
// assumes the design files and the memory model are compiled first; both builds share all control inputs
`timescale 1ns/1ns
`include "trace_sampler_map.svh"

module trace_sampler_tb_top import trace_sampler_pkg::*;;
   typedef struct {int cnt; int off;} note_s;
   logic sys_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic [`GROUP_N*`SAMPLE_W-1:0] group_data = '0;
   logic [`GROUP_SEL_W-1:0] group_num = 4'h1;
   logic trigger = 1'h0, arm = 1'h0, stop = 1'h0, selftest_req = 1'h0, compress_en = 1'h0, stuck_fault = 1'h0;
   sample_mode_e mode = MODE_NORMAL;
   trig_pos_e trig_pos = POS_MIDDLE;
   logic [15:0] cmp_mask = 16'h000f;
   logic [6:0] rd_addr = 7'h0;
   logic [15:0] rd_data, sram_wdata, sram_rdata, cur_val;
   logic busy, capture_done, held_bank, test_done, test_fail, test_done_x, test_fail_x, sram_data_oe, sram_we_n;
   logic [6:0] trig_addr, oldest_addr;
   logic [7:0] entry_count, sram_addr;
   logic [1:0] sram_card_sel;
   int failures = 0, n_checks = 0, cyc = 0, data_kind = 0, qn = 0;
   note_s notes[$];
   logic [15:0] qexp[$];
   logic done_q = 1'h0;
   trig_pos_e pos[3] = '{POS_EARLY, POS_MIDDLE, POS_LATE};
   int pct[3] = '{`PCT_EARLY, `PCT_MIDDLE, `PCT_LATE};

   trace_sampler i_trace_sampler (.sys_clk(sys_clk), .sys_rst(sys_rst), .group_data(group_data),
      .group_num(group_num), .trigger(trigger), .arm(arm), .stop(stop), .selftest_req(selftest_req), .mode(mode),
      .trig_pos(trig_pos), .compress_en(compress_en), .cmp_mask(cmp_mask), .rd_addr(rd_addr), .rd_data(rd_data),
      .busy(busy), .capture_done(capture_done), .trig_addr(trig_addr), .oldest_addr(oldest_addr),
      .entry_count(entry_count), .held_bank(held_bank), .test_done(test_done), .test_fail(test_fail),
      .sram_addr(), .sram_wdata(), .sram_data_oe(), .sram_we_n(), .sram_card_sel(), .sram_rdata(16'h0));

   // external build only takes part in the self-test checks; its trace readout is not inspected
   trace_sampler #(.EXT_MEM(1'h1), .STACK(2)) i_trace_sampler_ext (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .group_data(group_data), .group_num(group_num), .trigger(trigger), .arm(arm), .stop(stop),
      .selftest_req(selftest_req), .mode(mode), .trig_pos(trig_pos), .compress_en(compress_en), .cmp_mask(cmp_mask),
      .rd_addr(rd_addr), .rd_data(), .busy(), .capture_done(), .trig_addr(), .oldest_addr(), .entry_count(),
      .held_bank(), .test_done(test_done_x), .test_fail(test_fail_x), .sram_addr(sram_addr),
      .sram_wdata(sram_wdata), .sram_data_oe(sram_data_oe), .sram_we_n(sram_we_n), .sram_card_sel(sram_card_sel),
      .sram_rdata(sram_rdata));

   sram_model i_sram_model (.sys_clk(sys_clk), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
      .sram_data_oe(sram_data_oe), .sram_we_n(sram_we_n), .sram_card_sel(sram_card_sel),
      .stuck_fault(stuck_fault), .sram_rdata(sram_rdata));

   always #25 sys_clk = ~sys_clk;

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic pulse(ref logic s);
      s = 1'h1;
      tick(1);
      s = 1'h0;
   endtask

   function automatic logic flag(int k);
      return (k == 0) ? capture_done : (test_done & test_done_x);
   endfunction

   // bounded wait on a completion flag; running out ends the run as a failure
   task automatic wait_flag(int k, int lim);
      int i;
      i = 0;
      while (flag(k) !== 1'h1 && i < lim) begin
         tick(1);
         i++;
      end
      if (flag(k) !== 1'h1) begin
         failures++;
         $display("Error completion flag expected 1 seen %b", flag(k));
         tally_and_finish();
      end
   endtask

   // readout has one edge of latency in the on-chip build
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      rd_addr = a;
      tick(1);
      d = rd_data;
   endtask

   // normal capture with the trigger held off past the pre-trigger share so the buffer wraps
   task automatic capture(trig_pos_e p, int pre);
      logic [15:0] a, b;
      trig_pos = p;
      group_num = 4'($urandom_range(0, 8));
      notes.push_back('{`DEPTH_DEF, pre});
      pulse(arm);
      tick(pre + int'($urandom_range(2, 41)));
      trigger = 1'h1;
      wait_flag(0, 300);
      trigger = 1'h0;
      rd(oldest_addr, a);
      rd(trig_addr, b);
      cmp("trigger sample distance", 16'(pre), b - a);
      $display("capture test at %s done", p.name());
   endtask

   // probe stimulus: the selected group (0 or above 8 means group 1) carries a count, the rest noise
   always @(negedge sys_clk) begin
      cyc = cyc + 1;
      cur_val = (data_kind == 1) ? {12'h5a3, cyc[3:0]} : cyc[15:0];
      for (int g = 0; g < `GROUP_N; g++)
         group_data[g*16 +: 16] = 16'($urandom);
      group_data[((group_num == 4'h0 || group_num > 4'h8) ? 0 : int'(group_num) - 1)*16 +: 16] = cur_val;
   end

   // note each sample a qualified fill should store, in order
   always @(posedge sys_clk) begin
      if (mode == MODE_QUAL_FILL && busy === 1'h1 && trigger === 1'h1 && qn < `DEPTH_DEF) begin
         qexp.push_back(cur_val);
         qn++;
      end
   end

   // on each finished capture compare count and trigger placement with the oldest note
   always @(negedge sys_clk) begin
      note_s n;
      if (capture_done === 1'h1 && done_q !== 1'h1 && notes.size() > 0) begin
         n = notes.pop_front();
         if (n.cnt >= 0)
            cmp("entry_count", 16'(n.cnt), {8'h0, entry_count});
         if (n.off >= 0)
            cmp("trigger offset", 16'(n.off), {9'h0, 7'(trig_addr - oldest_addr)});
      end
      done_q <= capture_done;
   end

   initial begin
      logic [15:0] v;
      void'($urandom(32'h73ff8de8));
      tick(20);
      sys_rst = 1'h0;
      cmp("idle outputs", 16'h0, {7'h0, busy, entry_count});
      for (int r = 0; r < 6; r++)
         capture(pos[r % 3], `DEPTH_DEF * pct[r % 3] / `PCT_WHOLE);
      // masked bits toggle, unmasked ones stay put: only the first and the forced entry may land
      data_kind = 1;
      compress_en = 1'h1;
      for (int k = 1; k <= 2; k++) begin
         notes.push_back('{k, -1});
         pulse(arm);
         tick(k == 1 ? 60 : 100);
         pulse(stop);
         wait_flag(0, 10);
      end
      data_kind = 0;
      compress_en = 1'h0;
      $display("compression test done");
      mode = MODE_QUAL_FILL;
      notes.push_back('{`DEPTH_DEF, 0});
      pulse(arm);
      for (int k = 0; k < 600 && capture_done !== 1'h1; k++) begin
         trigger = 1'($urandom);
         tick(1);
      end
      trigger = 1'h0;
      wait_flag(0, 5);
      for (int k = 0; k < `DEPTH_DEF; k++) begin
         rd(7'(k), v);
         cmp("qualified sample", qexp[k], v);
      end
      $display("qualified fill test done");
      mode = MODE_QUAL_INTR;
      trigger = 1'h1;
      notes.push_back('{`DEPTH_DEF, 0});
      pulse(arm);
      tick(200);
      cmp("busy past full", 16'h1, {15'h0, busy});
      pulse(stop);
      wait_flag(0, 5);
      trigger = 1'h0;
      $display("qualified interrupt test done");
      // middle position: the first pulse of each round comes before enough history and must be refused
      mode = MODE_ALWAYS_ARMED;
      trig_pos = POS_MIDDLE;
      notes.push_back('{-1, -1});
      pulse(arm);
      for (int k = 0; k < 2; k++) begin
         tick(40);
         pulse(trigger);
         tick(39);
         pulse(trigger);
         tick(80);
         cmp("held bank", {15'h0, 1'(k)}, {15'h0, held_bank});
         cmp("busy while armed", 16'h1, {15'h0, busy});
         cmp("armed trigger offset", 16'(`DEPTH_DEF * `PCT_MIDDLE / `PCT_WHOLE),
            {9'h0, 7'(trig_addr - oldest_addr)});
      end
      pulse(stop);
      wait_flag(0, 5);
      $display("always armed test done");
      mode = MODE_NORMAL;
      for (int k = 0; k < 2; k++) begin
         stuck_fault = 1'(k);
         pulse(selftest_req);
         tick(1);
         wait_flag(1, 3000);
         cmp("on-chip self-test fail", 16'h0, {15'h0, test_fail});
         cmp("external self-test fail", 16'(k), {15'h0, test_fail_x});
      end
      $display("self-test test done");
      tally_and_finish();
   end
endmodule // trace_sampler_tb_top
